// *** include/sbsc_pkg.sv ***
package sbsc_pkg;

  // ram geometry
  localparam int ADDR_W = 10;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // sleep timing, figures in clock cycles
  localparam int SLEEP_ENTRY_TIME_CYC = 2;
  localparam int SLEEP_RECOVERY_TIME_CYC = 2;
  localparam logic [1:0] SLEEP_ENTRY_LAST = 2'(SLEEP_ENTRY_TIME_CYC - 1);
  localparam logic [1:0] SLEEP_RECOVERY_LAST =
    2'(SLEEP_RECOVERY_TIME_CYC - 1);

  // apb register map (byte addresses)
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_ADDR_W-1:0] REG_READ_COUNT = 12'h008;
  localparam logic [APB_ADDR_W-1:0] REG_WRITE_COUNT = 12'h00c;

  // control fields
  localparam int CTRL_OVERRIDE_BIT = 0;
  localparam int CTRL_INTERLEAVE_BIT = 1;
  localparam int CTRL_PIPELINED_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // status fields
  localparam int STAT_SLEEP_LSB = 0;
  localparam int STAT_BURST_BIT = 2;
  localparam int STAT_COUNT_LSB = 3;
  localparam int STAT_INTERLEAVE_BIT = 5;
  localparam int STAT_PIPELINED_BIT = 6;

  localparam int OP_COUNT_W = 16;
  localparam logic [OP_COUNT_W-1:0] OP_COUNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    SLP_AWAKE = 2'b00,
    SLP_ENTER = 2'b01,
    SLP_ASLEEP = 2'b11,
    SLP_WAKE = 2'b10
  } sbsc_sleep_e;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b11
  } sbsc_op_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } sbsc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sbsc_apb_rsp_s;

  // synchronous ram command pins, all active levels as named
  typedef struct packed {
    logic clkEnableN;
    logic chipSelectOneN;
    logic chipSelectTwo;
    logic chipSelectThreeN;
    logic writeN;
    logic advanceLoad;
    logic [LANES-1:0] laneSelectN;
    logic [ADDR_W-1:0] addr;
  } sbsc_cmd_s;

endpackage : sbsc_pkg

// *** rtl/sbsc_core.sv ***
// Notes on behaviour
// - advance/load high steps the burst counter and uses its address.
// - advance/load low with selection loads the external start address.
// - counter wraps to start after four accesses, start plus three.
// - burst order low steps low two bits linearly modulo four.
// - burst order high gives start XOR 00, 01, 10, 11.
// - flow-through select low gives flow-through; high or open pipelined.
// - sleep request defaults low; high enters sleep after two cycles.
// - sleep keeps stored data, configuration and internal state; the code clears burstActive while asleep.
// - after request falls, normal operation returns after two cycles.
// - asleep the device is deselected, ignores inputs, data undriven.
// - sleep request is asynchronous, active high, clock independent.
// - a held clock edge changes no control, data or counter state.
// - read begins with enable, three selects, write high, load low.
// - pipelined write data comes at third edge, matching read latency.
// - flow-through write data at second edge; reads one cycle earlier.
// - write with no lane selected writes nothing.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sbsc_core (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic arst_n, // async reset, active low
  input wire sbsc_pkg::sbsc_apb_req_s apbReq, // apb request
  output var sbsc_pkg::sbsc_apb_rsp_s apbRsp, // apb answer
  input wire sbsc_pkg::sbsc_cmd_s ramCmd, // synchronous command pins
  input wire logic [sbsc_pkg::DATA_W-1:0] dqIn, // data bus, in
  output var logic [sbsc_pkg::DATA_W-1:0] dqOut, // data bus, out
  output var logic dqOe, // data bus drive enable
  input wire logic burstOrderSelect, // strap: high interleaved
  input wire logic flowThroughSelectN, // strap: low flow-through
  input wire logic sleepRequest, // asynchronous sleep request
  output var logic sleeping // high while fully asleep
);
  import sbsc_pkg::*;

  // pin synchronisers: straps and the asynchronous sleep request
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic syncOrder;
  logic syncFlowN;
  logic syncSleep;

  // apb-visible configuration and counters
  logic [2:0] ctrl;
  logic [OP_COUNT_W-1:0] readCount;
  logic [OP_COUNT_W-1:0] writeCount;
  logic [31:0] rdData;
  logic rdErr;

  // sleep machine
  sbsc_sleep_e sleepState;
  logic [1:0] sleepCnt;

  // burst state
  logic burstActive;
  logic [BURST_W-1:0] burstCnt;
  logic [ADDR_W-1:0] burstBase;
  sbsc_op_e burstOp;

  // command issue, combinational
  logic edgeOn;
  logic selected;
  sbsc_op_e issueOp;
  logic [ADDR_W-1:0] issueAddr;
  logic [LANES-1:0] issueLanes;
  logic next_burstActive;
  logic [BURST_W-1:0] next_burstCnt;
  logic [ADDR_W-1:0] next_burstBase;
  sbsc_op_e next_burstOp;

  // late-write pipeline
  sbsc_op_e s1Op;
  logic [ADDR_W-1:0] s1Addr;
  logic [LANES-1:0] s1Lanes;
  sbsc_op_e s2Op;
  logic [ADDR_W-1:0] s2Addr;
  logic [LANES-1:0] s2Lanes;
  logic [DATA_W-1:0] rdStage;
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // effective modes
  logic interleaved;
  logic pipelined;
  logic [ADDR_W-1:0] wrAddr;
  logic [LANES-1:0] wrLanes;
  logic wrValid;

  // two flops per pin; only the second stage is read by logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= 3'b010; // pull-up on flow select, pull-down on sleep
      pinSync <= 3'b010;
    end else begin
      pinMeta <= {sleepRequest, flowThroughSelectN, burstOrderSelect};
      pinSync <= pinMeta;
    end
  end

  assign syncOrder = pinSync[0];
  assign syncFlowN = pinSync[1];
  assign syncSleep = pinSync[2];

  // software may override the straps, otherwise the pins decide
  assign interleaved = ctrl[CTRL_OVERRIDE_BIT] ?
    ctrl[CTRL_INTERLEAVE_BIT] : syncOrder;
  assign pipelined = ctrl[CTRL_OVERRIDE_BIT] ?
    ctrl[CTRL_PIPELINED_BIT] : syncFlowN;

  // sleep machine: entry and recovery each take a fixed cycle count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleepState <= SLP_AWAKE;
      sleepCnt <= 2'h0;
    end else begin
      unique case (sleepState)
        SLP_AWAKE: begin
          sleepCnt <= 2'h0;
          if (syncSleep) begin
            sleepState <= SLP_ENTER;
          end
        end
        SLP_ENTER: begin
          sleepCnt <= 2'(sleepCnt + 2'h1);
          if (!syncSleep) begin
            sleepState <= SLP_AWAKE;
          end else if (sleepCnt == SLEEP_ENTRY_LAST) begin
            sleepState <= SLP_ASLEEP;
            sleepCnt <= 2'h0;
          end
        end
        SLP_ASLEEP: begin
          sleepCnt <= 2'h0;
          if (!syncSleep) begin
            sleepState <= SLP_WAKE;
          end
        end
        SLP_WAKE: begin
          sleepCnt <= 2'(sleepCnt + 2'h1);
          if (syncSleep) begin
            sleepState <= SLP_ASLEEP;
            sleepCnt <= 2'h0;
          end else if (sleepCnt == SLEEP_RECOVERY_LAST) begin
            sleepState <= SLP_AWAKE;
          end
        end
      endcase
    end
  end

  assign sleeping = (sleepState == SLP_ASLEEP);

  // an edge counts only with clock enable low and the device awake or entering sleep;
  // recovery ignores commands so a stray write cannot land
  assign edgeOn = !ramCmd.clkEnableN &&
    (sleepState == SLP_AWAKE || sleepState == SLP_ENTER);
  assign selected = !ramCmd.chipSelectOneN && ramCmd.chipSelectTwo &&
    !ramCmd.chipSelectThreeN;

  // decode load, continue and deselect into one issued access
  always_comb begin
    issueOp = OP_IDLE;
    issueAddr = ramCmd.addr;
    issueLanes = '0;
    next_burstActive = burstActive;
    next_burstCnt = burstCnt;
    next_burstBase = burstBase;
    next_burstOp = burstOp;
    if (edgeOn) begin
      if (!ramCmd.advanceLoad) begin
        if (selected) begin
          issueOp = ramCmd.writeN ? OP_READ : OP_WRITE;
          next_burstBase = ramCmd.addr;
          next_burstCnt = BURST_CNT_RST;
          next_burstActive = 1'b1;
          next_burstOp = issueOp;
        end else begin
          next_burstActive = 1'b0;
        end
      end else if (burstActive) begin
        next_burstCnt = 2'(burstCnt + BURST_STEP); // wraps at four
        issueOp = burstOp;
        issueAddr[ADDR_W-1:BURST_W] = burstBase[ADDR_W-1:BURST_W];
        issueAddr[BURST_W-1:0] = interleaved ?
          (burstBase[BURST_W-1:0] ^ next_burstCnt) :
          2'(burstBase[BURST_W-1:0] + next_burstCnt);
      end
      if (issueOp == OP_WRITE) begin
        issueLanes = ~ramCmd.laneSelectN;
      end
    end
  end

  // burst registers; a held edge leaves them alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      burstActive <= 1'b0;
      burstCnt <= BURST_CNT_RST;
      burstBase <= '0;
      burstOp <= OP_IDLE;
    end else if (sleepState == SLP_ASLEEP) begin
      burstActive <= 1'b0;
    end else begin
      burstActive <= next_burstActive;
      burstCnt <= next_burstCnt;
      burstBase <= next_burstBase;
      burstOp <= next_burstOp;
    end
  end

  // late-write pipeline: two stages of address, op and lanes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1Op <= OP_IDLE;
      s1Addr <= '0;
      s1Lanes <= '0;
      s2Op <= OP_IDLE;
      s2Addr <= '0;
      s2Lanes <= '0;
    end else if (edgeOn) begin // frozen on hold and in sleep
      s1Op <= issueOp;
      s1Addr <= issueAddr;
      s1Lanes <= issueLanes;
      s2Op <= s1Op;
      s2Addr <= s1Addr;
      s2Lanes <= s1Lanes;
    end
  end

  // write data arrives one edge earlier in flow-through than pipelined
  assign wrAddr = pipelined ? s2Addr : s1Addr;
  assign wrLanes = pipelined ? s2Lanes : s1Lanes;
  assign wrValid = edgeOn &&
    ((pipelined ? s2Op : s1Op) == OP_WRITE);

  // array write per lane; no lane selected writes nothing
  always_ff @(posedge core_clk) begin
    if (wrValid) begin
      for (int i = 0; i < LANES; i++) begin
        if (wrLanes[i]) begin
          mem[wrAddr][i*LANE_W +: LANE_W] <= dqIn[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // read path: array read at the command edge, one more flop when
  // pipelined; a read of a word with a write still in flight returns
  // the old contents, the controller must not rely on forwarding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdStage <= '0;
      dqOut <= '0;
    end else if (edgeOn) begin
      rdStage <= mem[issueAddr];
      dqOut <= pipelined ? rdStage : mem[issueAddr];
    end
  end

  // bus drive: held edges keep a read driving, sleep releases the bus
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqOe <= 1'b0;
    end else if (sleepState == SLP_ASLEEP || sleepState == SLP_WAKE) begin
      dqOe <= 1'b0;
    end else if (sleepState == SLP_ENTER && syncSleep &&
                 sleepCnt == SLEEP_ENTRY_LAST) begin
      // let go on the edge that falls asleep, so the flag never overlaps
      // a driven bus even if a read slipped into the entry window
      dqOe <= 1'b0;
    end else if (edgeOn) begin
      dqOe <= pipelined ? (s1Op == OP_READ) : (issueOp == OP_READ);
    end
  end

  // operation counters, cleared by a write to their own offset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      readCount <= OP_COUNT_RST;
      writeCount <= OP_COUNT_RST;
    end else begin
      if (apbReq.psel && apbReq.penable && apbReq.pwrite &&
          apbReq.paddr == REG_READ_COUNT) begin
        readCount <= OP_COUNT_RST;
      end else if (issueOp == OP_READ) begin
        readCount <= OP_COUNT_W'(readCount + 1'b1);
      end
      if (apbReq.psel && apbReq.penable && apbReq.pwrite &&
          apbReq.paddr == REG_WRITE_COUNT) begin
        writeCount <= OP_COUNT_RST;
      end else if (issueOp == OP_WRITE && issueLanes != '0) begin
        writeCount <= OP_COUNT_W'(writeCount + 1'b1);
      end
    end
  end

  // control register write, taken at the access edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RST;
    end else if (apbReq.psel && apbReq.penable && apbReq.pwrite &&
                 apbReq.paddr == REG_CTRL) begin
      ctrl <= apbReq.pwdata[2:0];
    end
  end

  // read data is latched in the setup phase so prdata comes from flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= 32'h0;
      rdErr <= 1'b0;
    end else if (apbReq.psel && !apbReq.penable) begin
      rdData <= 32'h0;
      rdErr <= 1'b0;
      unique case (apbReq.paddr)
        REG_CTRL: rdData[2:0] <= ctrl;
        REG_STATUS: begin
          rdData[STAT_SLEEP_LSB +: 2] <= sleepState;
          rdData[STAT_BURST_BIT] <= burstActive;
          rdData[STAT_COUNT_LSB +: BURST_W] <= burstCnt;
          rdData[STAT_INTERLEAVE_BIT] <= interleaved;
          rdData[STAT_PIPELINED_BIT] <= pipelined;
        end
        REG_READ_COUNT: rdData[OP_COUNT_W-1:0] <= readCount;
        REG_WRITE_COUNT: rdData[OP_COUNT_W-1:0] <= writeCount;
        default: rdErr <= 1'b1; // unmapped offsets answer with an error
      endcase
    end
  end

  // zero-wait slave: ready in every access phase
  always_comb begin
    apbRsp.prdata = rdData;
    apbRsp.pready = apbReq.psel && apbReq.penable;
    apbRsp.pslverr = apbReq.psel && apbReq.penable && rdErr;
  end

endmodule : sbsc_core

`default_nettype wire

// *** verification/sbsc_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbsc_core_monitor (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire sbsc_pkg::sbsc_apb_req_s apbReq, // apb request
  input wire sbsc_pkg::sbsc_apb_rsp_s apbRsp, // apb answer
  input wire sbsc_pkg::sbsc_cmd_s ramCmd, // command pins
  input wire logic [sbsc_pkg::DATA_W-1:0] dqIn, // write data
  input wire logic [sbsc_pkg::DATA_W-1:0] dqOut, // read data
  input wire logic dqOe, // drive enable
  input wire logic burstOrderSelect, // order strap
  input wire logic flowThroughSelectN, // timing strap
  input wire logic sleepRequest, // sleep pin
  input wire logic sleeping // asleep flag
);
  import sbsc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic go;
  logic sel;
  // an enabled edge with the sleep pin low and the asleep flag clear
  assign go = !ramCmd.clkEnableN && !sleepRequest && !sleeping;
  assign sel = !ramCmd.chipSelectOneN && ramCmd.chipSelectTwo &&
    !ramCmd.chipSelectThreeN;
  sequence s_rd;
    go && sel && ramCmd.writeN && !ramCmd.advanceLoad;
  endsequence
  sequence s_wr;
    go && sel && !ramCmd.writeN && !ramCmd.advanceLoad;
  endsequence
  sequence s_cont;
    go && ramCmd.advanceLoad;
  endsequence
  a_apb_ready: assert property (apbReq.psel && apbReq.penable |->
    apbRsp.pready) else $error("pready low in access");
  a_sleep_quiet: assert property (sleeping |-> !dqOe)
    else $error("bus driven while asleep");
  a_sleep_entry: assert property ($rose(sleepRequest) ##1
    sleepRequest[*7] |-> sleeping) else $error("sleep not entered");
  a_wake_bound: assert property ($fell(sleepRequest) ##1
    !sleepRequest[*7] |-> !sleeping) else $error("sleep not left");
  a_hold_stable: assert property (ramCmd.clkEnableN &&
    !sleepRequest && !sleeping |=> $stable(dqOut) && $stable(dqOe))
    else $error("hold edge changed outputs");
  // straps pass a two stage synchroniser, so require them settled
  a_flow_read: assert property ((!flowThroughSelectN &&
    !sleeping)[*4] ##0 s_rd |=> dqOe) else $error("flow read late");
  a_pipe_read: assert property ((flowThroughSelectN &&
    !sleeping)[*4] ##0 s_rd ##1 !ramCmd.clkEnableN |=> dqOe)
    else $error("pipe read late");
  a_pipe_write: assert property ((flowThroughSelectN &&
    !sleeping)[*4] ##0 s_wr ##1 !ramCmd.clkEnableN |=> !dqOe)
    else $error("write slot driven");
  a_stale_cont: assert property (go && !sel &&
    !ramCmd.advanceLoad ##1 s_cont ##1 s_cont |=> !dqOe)
    else $error("continue after deselect drove bus");
endmodule : sbsc_core_monitor
bind sbsc_core sbsc_core_monitor u_mon (.core_clk(core_clk),
  .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp), .ramCmd(ramCmd),
  .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
  .burstOrderSelect(burstOrderSelect),
  .flowThroughSelectN(flowThroughSelectN),
  .sleepRequest(sleepRequest), .sleeping(sleeping));
`default_nettype wire

// *** verification/sbsc_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl_model (
  input wire logic core_clk, // clock
  input wire logic pipelined, // timing the ram is strapped for
  output var sbsc_pkg::sbsc_cmd_s ramCmd, // command pins
  output var logic [sbsc_pkg::DATA_W-1:0] dqIn // write data
);
  import sbsc_pkg::*;
  logic [DATA_W:0] s0;
  logic [DATA_W:0] s1;
  // start deselected with the bus idle
  initial begin
    ramCmd = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf, '0};
    dqIn = '0;
    s0 = '0;
    s1 = '0;
  end
  // one command per edge; late write data follows on its own slot,
  // otherwise the line toggles so stale data never looks valid
  task automatic send(input sbsc_cmd_s c, input logic w,
    input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    ramCmd <= c;
    s0 <= {w, d};
    s1 <= s0;
    if (pipelined) dqIn <= s1[DATA_W] ? s1[DATA_W-1:0] : ~dqIn;
    else dqIn <= s0[DATA_W] ? s0[DATA_W-1:0] : ~dqIn;
  endtask : send
endmodule : sbsc_ctrl_model
`default_nettype wire

// *** verification/test_sram_burst_sleep_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sram_burst_sleep_control;
  import sbsc_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 10'h2f4;
  logic core_clk, arst_n, dqOe, burst_order_select, ftN, slp, sleeping, er;
  sbsc_apb_req_s req;
  sbsc_apb_rsp_s rsp;
  sbsc_cmd_s cmd, cn, idl;
  logic [DATA_W-1:0] dqIn, dqOut, rd;
  logic [2:0] ev;
  logic [2:0][DATA_W-1:0] ed;
  logic [1:0] s, lo;
  // rows: order strap, timing strap, then the four two-bit low address values
  // that the burst must visit, start first
  logic [9:0] rows [8] = '{10'h16c, 10'h1b1, 10'h0c6, 10'h01b, 10'h34e,
    10'h3e4, 10'h2b1, 10'h21b};
  int fails, tests_run;
  sbsc_core uut (.core_clk(core_clk), .arst_n(arst_n), .apbReq(req),
    .apbRsp(rsp), .ramCmd(cmd), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .burstOrderSelect(burst_order_select), .flowThroughSelectN(ftN),
    .sleepRequest(slp), .sleeping(sleeping));
  sbsc_ctrl_model ctl (.core_clk(core_clk), .pipelined(ftN),
    .ramCmd(cmd), .dqIn(dqIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic sbsc_cmd_s mk(input logic e, l, w, v,
    input logic [LANES-1:0] n, input logic [ADDR_W-1:0] a);
    mk = '{e, ~l, l, ~l, w, v, n, a};
  endfunction : mk
  function automatic logic [DATA_W-1:0] dat(input logic [1:0] k);
    dat = 32'hc0de_0000 | 32'(k);
  endfunction : dat
  task automatic chk(input string n, input logic [DATA_W-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [APB_ADDR_W-1:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb
  // read data shows one edge after the command flowing, two pipelined
  task automatic step(input sbsc_cmd_s c, input logic w,
    input logic [DATA_W-1:0] d, input logic v, input logic [DATA_W-1:0] x);
    int l;
    ctl.send(c, w, d);
    ev = {ev[1:0], v};
    ed = {ed[1:0], x};
    l = ftN ? 2 : 1;
    #1;
    chk("dqOe", 32'(ev[l]), 32'(dqOe));
    if (ev[l]) chk("dqOut", ed[l], dqOut);
  endtask : step
  task automatic idle(input int n);
    repeat (n) step(idl, 1'b0, '0, 1'b0, '0);
  endtask : idle
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    req = '0;
    arst_n = 1'b0;
    burst_order_select = 1'b0;
    ftN = 1'b1;
    slp = 1'b0;
    ev = '0;
    ed = '0;
    fails = 0;
    tests_run = 0;
    cn = mk(1'b0, 1'b0, 1'b1, 1'b1, 4'hf, BASE);
    idl = mk(1'b0, 1'b0, 1'b1, 1'b0, 4'hf, BASE);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl reset", 32'(CTRL_RST), rd);
    apb(1'b0, 12'h010, '0);
    chk("unmapped err", 1, 32'(er));
    chk("unmapped data", 0, rd);
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl rw", 6, rd);
    $display("register test done");
    step(mk(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, BASE), 1'b1, dat(0), 1'b0, '0);
    for (int k = 1; k < 4; k++) step(mk(1'b0, 1'b0, 1'b1, 1'b1, 4'h0,
      BASE), 1'b1, dat(2'(k)), 1'b0, '0);
    step(mk(1'b0, 1'b1, 1'b0, 1'b0, 4'hf, BASE | 10'h1), 1'b1,
      32'hdead_beef, 1'b0, '0);
    idle(4);
    for (int r = 0; r < 8; r++) begin
      @(posedge core_clk);
      burst_order_select <= rows[r][9];
      ftN <= rows[r][8];
      s = rows[r][7:6];
      idle(3);
      for (int k = 0; k < 5; k++) begin
        lo = rows[r][7 - 2 * (k % 4) -: 2]; // fifth access wraps to start
        step(k == 0 ? mk(1'b0, 1'b1, 1'b1, 1'b0, 4'hf, BASE | 10'(s)) : cn,
          1'b0, '0, 1'b1, dat(lo));
      end
      idle(3);
    end
    $display("burst order test done");
    step(mk(1'b0, 1'b1, 1'b1, 1'b0, 4'hf, BASE), 1'b0, '0, 1'b1, dat(0));
    step(cn, 1'b0, '0, 1'b1, dat(1));
    step(mk(1'b1, 1'b0, 1'b1, 1'b1, 4'hf, BASE), 1'b0, '0, 1'b1, dat(1));
    step(cn, 1'b0, '0, 1'b1, dat(2));
    idle(1);
    repeat (2) step(cn, 1'b0, '0, 1'b0, '0);
    idle(2);
    $display("hold and deselect test done");
    @(posedge core_clk);
    slp <= 1'b1;
    // look at the flag only once the launching edge has settled
    for (int i = 0; i < 12 && sleeping !== 1'b1; i++) begin
      ctl.send(idl, 1'b0, '0);
      #1;
    end
    chk("asleep", 1, 32'(sleeping));
    ctl.send(mk(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, BASE), 1'b1, 32'h0bad_0bad);
    repeat (3) ctl.send(idl, 1'b0, '0);
    #1;
    chk("oe asleep", 0, 32'(dqOe));
    apb(1'b0, REG_STATUS, '0);
    chk("status asleep", 32'h33, rd);
    @(posedge core_clk);
    slp <= 1'b0;
    for (int i = 0; i < 12 && sleeping !== 1'b0; i++) begin
      ctl.send(idl, 1'b0, '0);
      #1;
    end
    chk("awake", 0, 32'(sleeping));
    repeat (4) ctl.send(idl, 1'b0, '0);
    step(mk(1'b0, 1'b1, 1'b1, 1'b0, 4'hf, BASE), 1'b0, '0, 1'b1, dat(0));
    idle(2);
    $display("sleep test done");
    apb(1'b0, REG_READ_COUNT, '0);
    chk("read count", 44, rd);
    apb(1'b0, REG_WRITE_COUNT, '0);
    chk("write count", 4, rd);
    apb(1'b1, REG_READ_COUNT, '0);
    apb(1'b0, REG_READ_COUNT, '0);
    chk("count clear", 0, rd);
    $display("counter test done");
    apb(1'b1, REG_CTRL, 32'h5);
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl set", 5, rd);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("oe reset", 0, 32'(dqOe));
    chk("out reset", 0, dqOut);
    chk("sleep reset", 0, 32'(sleeping));
    @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, REG_CTRL, '0);
    chk("ctrl after reset", 32'(CTRL_RST), rd);
    $display("reset test done");
    conclude();
  end
endmodule : test_sram_burst_sleep_control
`default_nettype wire
